// ==== hdl/dcc_channel.sv ====
// dcc_channel: one dma channel with its registers, arbitration and engine
// assumes a single clock, inputs synchronous to aclk, other channels'
// requests and priorities arriving as plain inputs
//
// Function
// - destination start built from two 16-bit halves
// - interrupt when match count equals index, pre-increment
// - match interrupt only with interrupt-allow bit set
// - transfer length plus one items moved
// - bit 13 picks level or rising-edge requests
// - bit 12 copies first source item everywhere
// - fill fetches source once; software sets dest increment
// - outside request mode, fill holds bus against other channels until done
// - bit 11 clear: back to back, bus locked
// - bit 11 set: idle cycle after each store
// - request mode ignores the blocking selection bit
// - highest three-bit priority wins the bus
// - equal priorities resolved by fixed ordering
// - equal priority: lower channel number wins
// - item index counts, forms addresses, clears at end
// - active bit clears at end unless circular
// - address steps 1, 2, 4 by width code
//
// Local design decision: the AXI4-Lite slave port.
`timescale 1ns/100ps
`default_nettype none
module dcc_channel
    import dcc_pkg::*;
(
    input  wire logic        aclk,
    input  wire logic        aresetn,
    input  wire logic [5:0]  awaddr,
    input  wire logic        awvalid,
    output logic             awready,
    input  wire logic [31:0] wdata,
    input  wire logic [3:0]  wstrb,
    input  wire logic        wvalid,
    output logic             wready,
    output logic [1:0]       bresp,
    output logic             bvalid,
    input  wire logic        bready,
    input  wire logic [5:0]  araddr,
    input  wire logic        arvalid,
    output logic             arready,
    output logic [31:0]      rdata,
    output logic [1:0]       rresp,
    output logic             rvalid,
    input  wire logic        rready,
    input  wire logic [31:0] src_start,
    input  wire logic        dreq,
    input  wire logic [3:0]  oth_req,
    input  wire logic [11:0] oth_prio,
    output logic             mem_req,
    output var dcc_mem_s     mem_cmd,
    input  wire logic        mem_ack,
    input  wire logic [31:0] mem_rdata,
    output logic             bus_lock,
    output logic             irq
);
    // *********************************************
    // declarations
    // *********************************************
    logic        awready_ff, wready_ff, bvalid_ff, arready_ff, rvalid_ff;
    logic [1:0]  bresp_ff, rresp_ff;
    logic [31:0] rdata_ff, nxt_rdata, wdat_ff;
    logic [1:0]  nxt_rresp;
    logic        aw_hold_ff, w_hold_ff, do_wr, nxt_aw_hold, nxt_w_hold;
    logic [3:0]  waddr_ff, wstrb_ff;
    logic [15:0] dst_lo_ff, dst_hi_ff, cnt_ff, len_ff, ctrl_ff, idx_ff;
    logic [1:0]  stat_ff, en_ff, set_ev, clr_ev, nxt_stat;
    logic        dreq_q_ff, pend_ff, trig, started, item_done, last;
    logic        win, irq_ff, mem_req_ff, bus_lock_ff;
    logic [3:0]  beat;
    logic [15:0] nxt_idx;
    logic [31:0] data_ff, nxt_data;
    dcc_state_e  state_ff, nxt_state;
    dcc_mem_s    mem_cmd_ff;
    logic        on, fill, dreqm, eff_idle, irqen;
    logic [2:0]  prio;
    logic [1:0]  item_w;

    assign on       = ctrl_ff[CB_ON];
    assign fill     = ctrl_ff[CB_INIT];
    assign dreqm    = ctrl_ff[CB_DREQ];
    assign eff_idle = ctrl_ff[CB_IDLE] & ~dreqm;
    assign irqen    = ctrl_ff[CB_IRQEN];
    assign prio     = ctrl_ff[CB_PRIO +: 3];
    assign item_w   = ctrl_ff[CB_WIDTH +: 2];
    assign last     = (idx_ff == len_ff);

    // byte-lane merge of a 16-bit register
    function automatic logic [15:0] merge16(input logic [15:0] old,
                                            input logic [31:0] d,
                                            input logic [3:0]  s);
        merge16 = {s[1] ? d[15:8] : old[15:8], s[0] ? d[7:0] : old[7:0]};
    endfunction : merge16

    // item address: start plus index scaled by width code
    function automatic logic [31:0] addr_of(input logic [31:0] start,
                                            input logic [15:0] ix,
                                            input logic        inc,
                                            input logic [1:0]  w);
        logic [31:0] off;
        off = {16'h0000, ix} << w;
        if (!inc || w == 2'b11) begin
            off = 32'h0000_0000; // reserved width code steps nothing
        end
        addr_of = start + off;
    endfunction : addr_of

    // *********************************************
    // axi4-lite write channel
    // *********************************************
    assign do_wr       = aw_hold_ff & w_hold_ff & ~bvalid_ff;
    assign nxt_aw_hold = (aw_hold_ff | (awvalid & awready_ff)) & ~do_wr;
    assign nxt_w_hold  = (w_hold_ff | (wvalid & wready_ff)) & ~do_wr;

    // address and data are held independently, answered once both are in
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_hold_ff <= 1'b0;
            w_hold_ff  <= 1'b0;
            awready_ff <= 1'b0;
            wready_ff  <= 1'b0;
            bvalid_ff  <= 1'b0;
            bresp_ff   <= RESP_OK;
            waddr_ff   <= 4'h0;
            wstrb_ff   <= 4'h0;
            wdat_ff    <= 32'h0000_0000;
        end else begin
            aw_hold_ff <= nxt_aw_hold;
            w_hold_ff  <= nxt_w_hold;
            awready_ff <= ~nxt_aw_hold;
            wready_ff  <= ~nxt_w_hold;
            if (awvalid && awready_ff) begin
                waddr_ff <= awaddr[5:2];
            end
            if (wvalid && wready_ff) begin
                wdat_ff  <= wdata;
                wstrb_ff <= wstrb;
            end
            if (do_wr) begin
                bvalid_ff <= 1'b1;
                bresp_ff  <= (waddr_ff > IX_IRQEN || waddr_ff == IX_IDX) ? RESP_ERR : RESP_OK;
            end else if (bvalid_ff && bready) begin
                bvalid_ff <= 1'b0;
            end
        end
    end

    // *********************************************
    // axi4-lite read channel
    // *********************************************
    // read mux; the clear register reads as zero
    always_comb begin
        nxt_rdata = 32'h0000_0000;
        nxt_rresp = RESP_OK;
        case (araddr[5:2])
            IX_DST_LO:  nxt_rdata[15:0] = dst_lo_ff;
            IX_DST_HI:  nxt_rdata[15:0] = dst_hi_ff;
            IX_IRQCNT:  nxt_rdata[15:0] = cnt_ff;
            IX_LEN:     nxt_rdata[15:0] = len_ff;
            IX_CTRL:    nxt_rdata[15:0] = ctrl_ff;
            IX_IDX:     nxt_rdata[15:0] = idx_ff;
            IX_IRQSTAT: nxt_rdata[1:0]  = stat_ff;
            IX_IRQCLR:  nxt_rdata       = 32'h0000_0000;
            IX_IRQEN:   nxt_rdata[1:0]  = en_ff;
            default:    nxt_rresp       = RESP_ERR;
        endcase
    end

    // one read in flight, answered the cycle after it is taken
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            arready_ff <= 1'b0;
            rvalid_ff  <= 1'b0;
            rdata_ff   <= 32'h0000_0000;
            rresp_ff   <= RESP_OK;
        end else if (arvalid && arready_ff) begin
            arready_ff <= 1'b0;
            rvalid_ff  <= 1'b1;
            rdata_ff   <= nxt_rdata;
            rresp_ff   <= nxt_rresp;
        end else if (rvalid_ff && rready) begin
            rvalid_ff  <= 1'b0;
            arready_ff <= 1'b1;
        end else begin
            arready_ff <= ~rvalid_ff;
        end
    end

    // *********************************************
    // channel registers
    // *********************************************
    // software write wins over the hardware clear of the active bit
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            dst_lo_ff <= RST_16;
            dst_hi_ff <= RST_16;
            cnt_ff    <= RST_16;
            len_ff    <= RST_16;
            ctrl_ff   <= RST_16;
            en_ff     <= 2'b00;
        end else begin
            if (item_done && last && !ctrl_ff[CB_CIRC]) begin
                ctrl_ff[CB_ON] <= 1'b0;
            end
            if (do_wr) begin
                case (waddr_ff)
                    IX_DST_LO: dst_lo_ff <= merge16(dst_lo_ff, wdat_ff, wstrb_ff);
                    IX_DST_HI: dst_hi_ff <= merge16(dst_hi_ff, wdat_ff, wstrb_ff);
                    IX_IRQCNT: cnt_ff    <= merge16(cnt_ff, wdat_ff, wstrb_ff);
                    IX_LEN:    len_ff    <= merge16(len_ff, wdat_ff, wstrb_ff);
                    IX_CTRL:   ctrl_ff   <= merge16(ctrl_ff, wdat_ff, wstrb_ff) & CTRL_WMASK;
                    IX_IRQEN:  en_ff     <= wstrb_ff[0] ? wdat_ff[1:0] : en_ff;
                    default:   ;
                endcase
            end
        end
    end

    // *********************************************
    // interrupt status: sticky, set wins over clear
    // *********************************************
    assign set_ev[IB_MATCH] = item_done & irqen & (cnt_ff == idx_ff);
    assign set_ev[IB_DONE]  = item_done & irqen & last;
    assign clr_ev   = (do_wr && waddr_ff == IX_IRQCLR && wstrb_ff[0]) ? wdat_ff[1:0] : 2'b00;
    assign nxt_stat = (stat_ff & ~clr_ev) | set_ev;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            stat_ff <= 2'b00;
            irq_ff  <= 1'b0;
        end else begin
            stat_ff <= nxt_stat;
            irq_ff  <= |(nxt_stat & en_ff);
        end
    end

    // *********************************************
    // peripheral request sensing
    // *********************************************
    // a rise seen while the pending flag is consumed is kept
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            dreq_q_ff <= 1'b0;
            pend_ff   <= 1'b0;
        end else begin
            dreq_q_ff <= dreq;
            pend_ff   <= (pend_ff & ~started) | (dreq & ~dreq_q_ff);
        end
    end
    assign trig = ctrl_ff[CB_SENSE] ? pend_ff : dreq;

    // *********************************************
    // arbitration against the other channels
    // *********************************************
    genvar j;
    generate
        for (j = 0; j < NCH; j++) begin : g_arb
            // a channel beats us on higher value, or equal value and lower number
            assign beat[j] = (j != OWN_CH) && oth_req[j] &&
                             ((oth_prio[3*j +: 3] > prio) ||
                              (oth_prio[3*j +: 3] == prio && j < OWN_CH));
        end
    endgenerate
    assign win = ~|beat;

    // *********************************************
    // transfer engine
    // *********************************************
    // arbitration only happens from idle; outside request mode, fill and blocking
    // runs never return there mid-transfer, so nobody can preempt them
    always_comb begin
        nxt_state = state_ff;
        nxt_idx   = idx_ff;
        started   = 1'b0;
        item_done = 1'b0;
        nxt_data  = data_ff;
        case (state_ff)
            ST_IDLE: begin
                if (!on) begin
                    nxt_idx = 16'h0000;
                end else if ((!dreqm || trig) && win) begin
                    started   = 1'b1;
                    nxt_state = (fill && idx_ff != 16'h0000) ? ST_WRITE : ST_READ;
                end
            end
            ST_READ: begin
                if (mem_ack) begin
                    nxt_data  = mem_rdata;
                    nxt_state = ST_WRITE;
                end
            end
            ST_WRITE: begin
                if (mem_ack) begin
                    item_done = 1'b1;
                    nxt_idx   = last ? 16'h0000 : 16'(idx_ff + 16'h0001);
                    if (last || !on || dreqm) begin
                        nxt_state = ST_IDLE;
                    end else if (eff_idle) begin
                        nxt_state = ST_GAP;
                    end else if (fill) begin
                        nxt_state = ST_WRITE;
                    end else begin
                        nxt_state = ST_READ;
                    end
                end
            end
            ST_GAP: begin
                nxt_state = (fill && on) ? ST_WRITE : ST_IDLE;
            end
            default: nxt_state = ST_IDLE;
        endcase
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state_ff <= ST_IDLE;
            idx_ff   <= RST_16;
            data_ff  <= 32'h0000_0000;
        end else begin
            state_ff <= nxt_state;
            idx_ff   <= nxt_idx;
            data_ff  <= nxt_data;
        end
    end

    // memory command registered from the next state and index
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            mem_req_ff  <= 1'b0;
            mem_cmd_ff  <= '0;
            bus_lock_ff <= 1'b0;
        end else begin
            mem_req_ff       <= (nxt_state == ST_READ) || (nxt_state == ST_WRITE);
            mem_cmd_ff.we    <= (nxt_state == ST_WRITE);
            mem_cmd_ff.size  <= item_w;
            mem_cmd_ff.wdata <= nxt_data;
            mem_cmd_ff.addr  <= (nxt_state == ST_WRITE) ?
                                addr_of({dst_hi_ff, dst_lo_ff}, nxt_idx, ctrl_ff[CB_DINC], item_w) :
                                addr_of(src_start, nxt_idx, ctrl_ff[CB_SINC] & ~fill, item_w);
            bus_lock_ff      <= (nxt_state != ST_IDLE) && !eff_idle;
        end
    end

    assign awready  = awready_ff;
    assign wready   = wready_ff;
    assign bvalid   = bvalid_ff;
    assign bresp    = bresp_ff;
    assign arready  = arready_ff;
    assign rvalid   = rvalid_ff;
    assign rdata    = rdata_ff;
    assign rresp    = rresp_ff;
    assign mem_req  = mem_req_ff;
    assign mem_cmd  = mem_cmd_ff;
    assign bus_lock = bus_lock_ff;
    assign irq      = irq_ff;

    // *********************************************
    // assertions
    // *********************************************
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    property p_idx_wrap;
        item_done && last |=> idx_ff == 16'h0000;
    endproperty
    a_idx_wrap: assert property (p_idx_wrap) else $error("index not cleared at end");

    property p_match;
        item_done && irqen && cnt_ff == idx_ff |=> stat_ff[IB_MATCH] ##1 irq == en_ff[IB_MATCH] || stat_ff[IB_DONE];
    endproperty
    a_match: assert property (p_match) else $error("count match not flagged");

    property p_allow;
        $rose(stat_ff[IB_MATCH]) |-> $past(irqen);
    endproperty
    a_allow: assert property (p_allow) else $error("match flagged without allow bit");

    property p_stop;
        item_done && last && !ctrl_ff[CB_CIRC] && !do_wr |=> !on ##1 state_ff == ST_IDLE;
    endproperty
    a_stop: assert property (p_stop) else $error("active bit kept after end");

    property p_circ;
        item_done && last && ctrl_ff[CB_CIRC] && !do_wr |=> on && idx_ff == 16'h0000;
    endproperty
    a_circ: assert property (p_circ) else $error("circular run stopped");

    property p_fill_once;
        state_ff == ST_READ |-> !(fill && idx_ff != 16'h0000);
    endproperty
    a_fill_once: assert property (p_fill_once) else $error("fill fetched source twice");

    property p_gap;
        state_ff == ST_WRITE && mem_ack && !last && on && eff_idle |=> !mem_req ##1 mem_req == fill;
    endproperty
    a_gap: assert property (p_gap) else $error("no idle cycle after store");

    property p_b2b;
        state_ff == ST_WRITE && mem_ack && !last && on && !eff_idle && !dreqm |=> mem_req && bus_lock;
    endproperty
    a_b2b: assert property (p_b2b) else $error("blocking run left a gap");

    property p_tie;
        state_ff == ST_IDLE ##1 state_ff != ST_IDLE |-> !$past(oth_req[0] && oth_prio[2:0] >= prio);
    endproperty
    a_tie: assert property (p_tie) else $error("lost tie or lower priority granted");

    property p_edge;
        state_ff == ST_IDLE && on && dreqm && ctrl_ff[CB_SENSE] && !pend_ff |=> state_ff == ST_IDLE;
    endproperty
    a_edge: assert property (p_edge) else $error("started without request edge");

    property p_dst;
        mem_req && mem_cmd.we && idx_ff == 16'h0000 |-> mem_cmd.addr == {dst_hi_ff, dst_lo_ff};
    endproperty
    a_dst: assert property (p_dst) else $error("first store not at destination start");

    property p_rsvd;
        ctrl_ff[15:14] == 2'b00;
    endproperty
    a_rsvd: assert property (p_rsvd) else $error("reserved control bits set");

    c_fill: cover property (fill && item_done && last);
    c_circ: cover property (ctrl_ff[CB_CIRC] && item_done && last);
    c_gap:  cover property (state_ff == ST_GAP);
endmodule : dcc_channel
`default_nettype wire

// ==== hdl/dcc_pkg.sv ====
// dcc_pkg: constants, types and register map of one dma channel
// assumes an axi4-lite host and a simple req/ack memory port
package dcc_pkg;
    // *********************************************
    // register map
    // *********************************************
    localparam logic [31:0] REG_BASE   = 32'h50003634;
    localparam logic [31:0] OFF_DST_LO = 32'h50003634;
    localparam logic [31:0] OFF_DST_HI = 32'h50003636;
    localparam logic [31:0] OFF_IRQCNT = 32'h50003638;
    localparam logic [31:0] OFF_LEN    = 32'h5000363a;
    localparam logic [31:0] OFF_CTRL   = 32'h5000363c;
    localparam logic [31:0] OFF_IDX    = 32'h5000363e;
    // word index on the bus, byte address is four times it
    localparam logic [3:0] IX_DST_LO  = 4'((OFF_DST_LO - REG_BASE) >> 1);
    localparam logic [3:0] IX_DST_HI  = 4'((OFF_DST_HI - REG_BASE) >> 1);
    localparam logic [3:0] IX_IRQCNT  = 4'((OFF_IRQCNT - REG_BASE) >> 1);
    localparam logic [3:0] IX_LEN     = 4'((OFF_LEN - REG_BASE) >> 1);
    localparam logic [3:0] IX_CTRL    = 4'((OFF_CTRL - REG_BASE) >> 1);
    localparam logic [3:0] IX_IDX     = 4'((OFF_IDX - REG_BASE) >> 1);
    localparam logic [3:0] IX_IRQSTAT = 4'h6;
    localparam logic [3:0] IX_IRQCLR  = 4'h7;
    localparam logic [3:0] IX_IRQEN   = 4'h8;
    // *********************************************
    // control word fields
    // *********************************************
    localparam int CB_ON    = 0;
    localparam int CB_WIDTH = 1;
    localparam int CB_IRQEN = 3;
    localparam int CB_DREQ  = 4;
    localparam int CB_DINC  = 5;
    localparam int CB_SINC  = 6;
    localparam int CB_CIRC  = 7;
    localparam int CB_PRIO  = 8;
    localparam int CB_IDLE  = 11;
    localparam int CB_INIT  = 12;
    localparam int CB_SENSE = 13;
    localparam logic [15:0] CTRL_WMASK = 16'h3fff;
    localparam logic [15:0] RST_16     = 16'h0000;
    // *********************************************
    // interrupt bits, bus answers, arbitration
    // *********************************************
    localparam int IB_MATCH = 0;
    localparam int IB_DONE  = 1;
    localparam logic [1:0] RESP_OK  = 2'b00;
    localparam logic [1:0] RESP_ERR = 2'b10;
    localparam int NCH    = 4;
    localparam int OWN_CH = 3;
    typedef enum logic [1:0] {ST_IDLE, ST_READ, ST_WRITE, ST_GAP} dcc_state_e;
    typedef struct packed {
        logic        we;
        logic [1:0]  size;
        logic [31:0] addr;
        logic [31:0] wdata;
    } dcc_mem_s;
endpackage : dcc_pkg

// ==== testbench/dcc_mem_model.sv ====
// dcc_mem_model: memory and peripheral space behind the channel
// assumes one access at a time, command held until the ack pulse
`timescale 1ns/100ps
`default_nettype none
module dcc_mem_model
    import dcc_pkg::*;
(
    input  wire logic     aclk,
    input  wire logic     aresetn,
    input  wire logic     mem_req,
    input  wire dcc_mem_s mem_cmd,
    output logic          mem_ack,
    output logic [31:0]   mem_rdata
);
    // ****************************************
    // answer path
    // ****************************************
    logic [1:0] wait_ff;
    // latency 1..4 so prompt and slow answers both occur; data scrambles outside the ack
    always_ff @(posedge aclk) begin
        mem_rdata <= $urandom;
        if (!aresetn || !mem_req || mem_ack) begin
            mem_ack <= 1'b0;
            wait_ff <= 2'($urandom);
        end else if (wait_ff == 2'h0) begin
            mem_ack <= 1'b1;
        end else begin
            wait_ff <= wait_ff - 2'h1;
        end
    end
endmodule : dcc_mem_model
`default_nettype wire

// ==== testbench/testbench.sv ====
// testbench: register, transfer, interrupt and arbitration checks of dcc_channel
// assumes the memory model as far side and other channels driven from here
`timescale 1ns/100ps
`default_nettype none
module testbench;
    import dcc_pkg::*;
    localparam logic [15:0] K_ON = 16'h0001, K_IRQ = 16'h0008, K_DINC = 16'h0020;
    localparam logic [15:0] K_SINC = 16'h0040, K_IDLE = 16'h0800, K_FILL = 16'h1000;
    logic        aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, dreq;
    logic        awready, wready, bvalid, arready, rvalid, mem_req, mem_ack, bus_lock, irq;
    logic [5:0]  awaddr, araddr;
    logic [31:0] wdata, rdata, src_start, mem_rdata, last_rd, q;
    logic [3:0]  wstrb, oth_req;
    logic [11:0] oth_prio;
    logic [1:0]  bresp, rresp, r;
    dcc_mem_s    mem_cmd;
    dcc_mem_s    exp_q[$];
    logic        gap_chk = 1'b0, idle_mode;
    int          miscompares, n_compared, cycles;

    dcc_channel dcc_channel_i (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid),
        .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
        .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready),
        .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready), .src_start(src_start),
        .dreq(dreq), .oth_req(oth_req), .oth_prio(oth_prio), .mem_req(mem_req), .mem_cmd(mem_cmd),
        .mem_ack(mem_ack), .mem_rdata(mem_rdata), .bus_lock(bus_lock), .irq(irq));
    dcc_mem_model dcc_mem_model_i (.aclk(aclk), .aresetn(aresetn), .mem_req(mem_req),
        .mem_cmd(mem_cmd), .mem_ack(mem_ack), .mem_rdata(mem_rdata));

    // ****************************************
    // clock, timeout, checking
    // ****************************************
    initial begin
        aclk = 1'b0;
        forever #5 aclk = ~aclk;
    end
    task automatic chk(input logic [35:0] seen, input logic [35:0] exp);
        n_compared++;
        if (seen !== exp) begin
            miscompares++;
            $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask : chk
    task automatic tally_and_finish();
        $display("compared %0d mismatched %0d", n_compared, miscompares);
        if (miscompares == 0 && n_compared > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : tally_and_finish
    // the whole run needs well under two thousand cycles; the ceiling leaves ample room
    always @(posedge aclk) begin
        cycles++;
        if (cycles == 30000) begin
            miscompares++;
            tally_and_finish();
        end
    end
    // memory traffic against the expected queue; wdata must repeat the item's fetched data
    always @(posedge aclk) begin
        if (gap_chk) chk(mem_req, 0);
        gap_chk = 1'b0;
        if (aresetn && mem_req && mem_ack) begin
            if (mem_cmd.we) chk(mem_cmd.wdata, last_rd);
            else last_rd = mem_rdata;
            chk(exp_q.size() > 0, 1);
            if (exp_q.size() > 0) begin
                chk({mem_cmd.we, mem_cmd.size, mem_cmd.addr}, {exp_q[0].we, exp_q[0].size, exp_q[0].addr});
                void'(exp_q.pop_front());
            end
            gap_chk = mem_cmd.we && idle_mode;
            chk(bus_lock, !idle_mode);
        end
    end

    // ****************************************
    // bus master and transfer tasks
    // ****************************************
    task automatic axi(input bit wr, input logic [3:0] ix, input logic [31:0] d);
        awaddr  <= {ix, 2'b00};
        araddr  <= {ix, 2'b00};
        wdata   <= d;
        awvalid <= wr;
        wvalid  <= wr;
        bready  <= wr;
        arvalid <= !wr;
        rready  <= !wr;
        do begin
            @(posedge aclk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
            if (arready) arvalid <= 1'b0;
        end while (!(wr ? bvalid : rvalid));
        q = rdata;
        r = wr ? bresp : rresp;
        bready <= 1'b0;
        rready <= 1'b0;
        @(posedge aclk); // one edge between transfers, no double assignment
    endtask : axi
    // program, queue the expected accesses, optionally stall on a rival, wait for the end
    task automatic run(input logic [15:0] len, input logic [15:0] ctl, input int stall);
        logic [31:0] dst;
        int          w;
        dst = $urandom;
        w = int'(ctl[2:1]);
        idle_mode = ctl[CB_IDLE] && !ctl[CB_DREQ]; // request mode ignores the idle bit
        axi(1, IX_DST_LO, {16'h0, dst[15:0]});
        axi(1, IX_DST_HI, {16'h0, dst[31:16]});
        axi(1, IX_LEN, {16'h0, len});
        for (int i = 0; i <= int'(len); i++) begin
            if (i == 0 || !ctl[CB_INIT]) exp_q.push_back('{1'b0, 2'(w), src_start + (ctl[CB_SINC] ? i << w : 0), 0});
            exp_q.push_back('{1'b1, 2'(w), dst + (ctl[CB_DINC] ? i << w : 0), 0});
        end
        axi(1, IX_CTRL, {16'h0, ctl});
        for (int i = 0; i < stall; i++) begin
            @(posedge aclk);
            chk(mem_req, 0);
        end
        oth_req <= stall > 0 ? 4'h0 : oth_req;
        if (ctl[CB_DREQ] && stall > 0) begin
            dreq <= 1'b0;
            @(posedge aclk);
            dreq <= 1'b1;
        end
        q = 32'h1;
        for (int n = 0; n < 100 && q[CB_ON]; n++) axi(0, IX_CTRL, 0);
        chk(q[CB_ON], 0);
        chk(exp_q.size(), 0);
        axi(0, IX_IDX, 0);
        chk(q, 0);
    endtask : run

    // ****************************************
    // main sequence
    // ****************************************
    initial begin
        void'($urandom(32'h46e28674));
        {awvalid, wvalid, bready, arvalid, rready, dreq, idle_mode} <= 7'h00;
        {awaddr, araddr, wdata, oth_req, oth_prio} <= 0;
        aresetn <= 1'b0;
        wstrb <= 4'hf;
        src_start <= $urandom;
        repeat (3) @(posedge aclk);
        aresetn <= 1'b1;
        repeat (2) @(posedge aclk);
        for (int i = 0; i < 9; i++) begin
            axi(0, 4'(i), 0);
            chk({r, q}, {RESP_OK, 32'h0});
        end
        axi(0, 4'h9, 0);
        chk(r, RESP_ERR);
        axi(1, IX_IDX, 32'h5);
        chk(r, RESP_ERR);
        axi(1, IX_CTRL, 32'hc000);
        axi(0, IX_CTRL, 0);
        chk(q, 0);
        $display("test registers done");
        // width codes 0 to 2, one with gaps, one without source step
        for (int w = 0; w < 3; w++) run(16'($urandom_range(3)), K_ON | K_DINC | (w == 2 ? 0 : K_SINC) | 16'(w << 1) | (w == 1 ? K_IDLE : 0), 0);
        run(16'h0, K_ON | K_DINC | K_SINC, 0);
        run(16'h3, K_ON | K_FILL | K_DINC | K_SINC, 0);
        $display("test transfers done");
        axi(1, IX_IRQEN, 32'h1);
        axi(1, IX_IRQCNT, 32'h1);
        run(16'h2, K_ON | K_DINC | K_IRQ, 0);
        chk(irq, 1);
        axi(0, IX_IRQSTAT, 0);
        chk(q[IB_MATCH], 1);
        axi(1, IX_IRQCLR, 32'h3);
        @(posedge aclk);
        chk(irq, 0);
        run(16'h2, K_ON | K_DINC, 0);
        chk(irq, 0);
        $display("test interrupt done");
        oth_req <= 4'h1;
        oth_prio <= 12'h007;
        run(16'h1, K_ON | K_DINC | 16'h0300, 20);
        oth_req <= 4'h1;
        oth_prio <= 12'h000;
        run(16'h1, K_ON | K_DINC, 20);
        oth_req <= 4'h1;
        oth_prio <= 12'h003;
        run(16'h1, K_ON | K_DINC | 16'h0700, 0);
        oth_req <= 4'h0;
        $display("test arbitration done");
        // edge mode waits for a rise, level mode runs on a held request
        run(16'h0, K_ON | K_DINC | 16'h2010, 20);
        run(16'h1, K_ON | K_DINC | K_IDLE | 16'h0010, 0);
        run(16'h0, K_ON | K_DINC | 16'h2010, 20);
        $display("test requests done");
        tally_and_finish();
    end
endmodule : testbench
`default_nettype wire
